/* File: adc_serial_config_port_pkg.sv */
package adc_serial_config_port_pkg;

  // Instruction word layout, counted in bits of the assembled 16-bit word.
  localparam int INSTR_BITS    = 16;
  localparam int INSTR_RW_BIT  = 15;
  localparam int INSTR_WL_HI   = 14;
  localparam int INSTR_WL_LO   = 13;
  localparam int ADDR_BITS     = 13;
  localparam int BYTE_BITS     = 8;

  // Word-length codes carried in the instruction.
  localparam logic [1:0] LEN_ONE    = 2'h0;
  localparam logic [1:0] LEN_TWO    = 2'h1;
  localparam logic [1:0] LEN_THREE  = 2'h2;
  localparam logic [1:0] LEN_STREAM = 2'h3;

  // Register offsets.
  localparam logic [12:0] ADDR_PORT_CFG  = 13'h0000;
  localparam logic [12:0] ADDR_CHIP_ID   = 13'h0001;
  localparam logic [12:0] ADDR_GRADE     = 13'h0002;
  localparam logic [12:0] ADDR_INDEX     = 13'h0005;
  localparam logic [12:0] ADDR_PROG_LO   = 13'h0008;
  localparam logic [12:0] ADDR_PROG_HI   = 13'h0025;
  localparam logic [12:0] ADDR_TRANSFER  = 13'h00ff;
  localparam int          PROG_COUNT     = 30;

  // Port configuration field positions, mirrored in both nibbles.
  localparam int CFG_LSB_HI   = 6;
  localparam int CFG_RST_HI   = 5;
  localparam int CFG_RST_LO   = 2;
  localparam int CFG_LSB_LO   = 1;
  localparam int XFER_BIT     = 0;

  // Reset values.
  localparam logic [7:0] PORT_CFG_DEFAULT = 8'h18;
  localparam logic [7:0] GRADE_DEFAULT    = 8'h00;
  localparam logic [1:0] INDEX_DEFAULT    = 2'h3;
  localparam logic [7:0] PROG_DEFAULT     = 8'h00;

  // Cycles after reset release before the strap level is trusted.
  localparam logic [1:0] STRAP_SETTLE     = 2'h2;

endpackage

/* File: adc_serial_config_port.sv */
// What this block does
// (R1) Frame starts: select low, then clock rise.
// (R2) Select high ignores clock and data.
// (R3) Select held low streams bytes continuously when the word-length code is streaming.
// (R4) Select high between bytes keeps place in counted frames; a streaming frame ends.
// (R5) Select high tristates data pin.
// (R6) Frame opens with 16-bit instruction.
// (R7) Word-length bits set data byte count.
// (R8) Data moves as bytes; storage byte-wide.
// (R9) Instruction bit 15 selects read/write; it is the first bit sent only in MSB-first order.
// (R10) Readback turns data pin to output.
// (R11) MSB first default; config selects LSB first.
// (R12) Clock, select inputs; data pin input on writes.
// (R13) Host keeps port idle during sampling.
// (R14) Power-on data pin level picks power-down.
// (R15) Output-enable strap high tristates outputs.
// (R16) Pin mode: pins act as static controls.
// (R17) Select tied high disables serial port.
// (R18) Host writes zeros to unused bits.
// (R19) Host never writes unpopulated locations.
// (R20) Reset loads default register values.
// (R21) Decode config, index/transfer, program ranges.
// (R22) Program writes shadowed until transfer; self-clears.
// (R23) Index bits pick channel A, B, both.
// (R24) Both selected reads channel A; globals ignore.
// (R25) Port config mirrored nibbles, default 0x18.
// (R26) Instruction: rw, two length bits, address.
// (R27) Sample on rising, drive on falling edges.
module adc_serial_config_port #(
  parameter logic [7:0] CHIP_ID = 8'h5c  // Arbitrary identification value.
) (
  input  wire logic       clk_sys_i,              // System clock, 10 MHz.
  input  wire logic       rst_n_i,                // Asynchronous reset, active low.
  input  wire logic       sclk_i,                 // Serial clock pin.
  input  wire logic       chip_select_low_n_i,    // Chip select pin, active low.
  input  wire logic       data_or_powerdown_pin_i,// Data pin level seen from outside.
  input  wire logic       output_enable_n_i,      // Output-enable strap pin, active low.
  input  wire logic [4:0] cfg_index_i,            // Program register index to observe.
  output logic            data_or_powerdown_pin_o,// Data pin drive value.
  output logic            data_pin_oe_o,          // High while the block drives the pin.
  output logic            lsb_first_o,            // Shift order, high for LSB first.
  output logic [1:0]      chan_select_o,          // Channel index bits.
  output logic            full_power_down_o,      // Converter power-down request.
  output logic            outputs_hiz_o,          // Output data drivers in high impedance.
  output logic            transfer_o,             // One-cycle pulse on shadow transfer.
  output logic [7:0]      cfg_data_a_o,           // Active channel A program register.
  output logic [7:0]      cfg_data_b_o            // Active channel B program register.
);
  import adc_serial_config_port_pkg::*;
  typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA} port_state_t;
  // Reverses the order of eight bits.
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  // Next address of a multibyte transfer: down in MSB-first, up in LSB-first.
  function automatic logic [12:0] step_addr(input logic [12:0] a, input logic lsb);
    return lsb ? 13'(a + 13'h0001) : 13'(a - 13'h0001);
  endfunction

  // Synchroniser stages for every pin; the first stage feeds only the second.
  logic sclk_m, sclk_s, sclk_d;      // Serial clock stages and edge delay.
  logic cs_m, cs_s;                  // Chip select stages.
  logic sd_m, sd_s;                  // Data pin stages.
  logic oe_m, oe_s;                  // Output-enable strap stages.
  // Pin synchronisers.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      cs_m   <= 1'b1;
      cs_s   <= 1'b1;
      sd_m   <= 1'b0;
      sd_s   <= 1'b0;
      oe_m   <= 1'b0;
      oe_s   <= 1'b0;
    end else begin
      sclk_m <= sclk_i;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      cs_m   <= chip_select_low_n_i;
      cs_s   <= cs_m;
      sd_m   <= data_or_powerdown_pin_i;
      sd_s   <= sd_m;
      oe_m   <= output_enable_n_i;
      oe_s   <= oe_m;
    end
  end

  // Clock edges count only while select is low.
  logic rise;                        // Qualified rising serial clock edge.
  logic fall;                        // Qualified falling serial clock edge.
  assign rise = sclk_s & ~sclk_d & ~cs_s;  // [R2] [R27]
  assign fall = ~sclk_s & sclk_d & ~cs_s;  // [R2] [R27]
  port_state_t state;                // Frame position.
  logic [15:0] shreg;                // Incoming bit shifter.
  logic [15:0] next_sh;              // Shifter including the bit now sampled.
  logic [3:0]  bitcnt;               // Bit position in instruction or byte.
  logic        is_read;              // Current frame reads.
  logic [1:0]  len_code;             // Word-length code of the frame.
  logic [1:0]  bytes_done;           // Bytes finished in a counted frame.
  logic [12:0] addr;                 // Address of the current data byte.
  logic [7:0]  rd_byte;              // Byte being shifted out.
  logic [7:0]  rd_val;               // Read data for the next byte.
  logic [12:0] rd_addr;              // Address of the next byte.
  logic [15:0] instr;                // Instruction in canonical order.
  logic [7:0]  wr_byte;              // Finished data byte in canonical order.
  logic        instr_done;           // Sixteenth instruction bit sampled.
  logic        byte_done;            // Eighth data bit sampled.
  logic        last_byte;            // The byte now done ends the frame.
  logic        soft_rst;             // Soft reset written this cycle.
  logic        xfer;                 // Transfer written this cycle.
  assign next_sh    = {shreg[14:0], sd_s};
  assign instr      = lsb_first_o ? {rev8(next_sh[7:0]), rev8(next_sh[15:8])} : next_sh;  // [R11]
  assign wr_byte    = lsb_first_o ? rev8(next_sh[7:0]) : next_sh[7:0];  // [R8] [R11]
  assign instr_done = rise && state == ST_INSTR && bitcnt == 4'hf;  // [R6]
  assign byte_done  = rise && state == ST_DATA && bitcnt == 4'h7;  // [R8]
  assign last_byte  = len_code != LEN_STREAM && bytes_done == len_code;  // [R7]

  // Frame sequencing: instruction, then bytes until the length runs out.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state      <= ST_IDLE;
      bitcnt     <= '0;
      shreg      <= '0;
      is_read    <= 1'b0;
      len_code   <= LEN_ONE;
      bytes_done <= '0;
      addr       <= '0;
    end else if (cs_s) begin
      // Select high: a counted frame between bytes waits, anything else ends.
      if (!(state == ST_DATA && bitcnt == 4'h0 && len_code != LEN_STREAM)) begin
        state  <= ST_IDLE;  // [R4] [R17]
        bitcnt <= '0;
      end
    end else if (rise) begin
      shreg <= next_sh;
      case (state)
        ST_IDLE: begin
          state  <= ST_INSTR;  // [R1]
          bitcnt <= 4'h1;
        end
        ST_INSTR: begin
          bitcnt <= 4'(bitcnt + 4'h1);
          if (instr_done) begin
            state      <= ST_DATA;  // [R6]
            bitcnt     <= '0;
            is_read    <= instr[INSTR_RW_BIT];  // [R9] [R26]
            len_code   <= instr[INSTR_WL_HI:INSTR_WL_LO];  // [R7] [R26]
            bytes_done <= '0;
            addr       <= instr[ADDR_BITS-1:0];  // [R26]
          end
        end
        ST_DATA: begin
          bitcnt <= 4'(bitcnt + 4'h1);
          if (byte_done) begin
            bitcnt     <= '0;
            addr       <= step_addr(addr, lsb_first_o);
            bytes_done <= 2'(bytes_done + 2'h1);
            if (last_byte) begin
              state <= ST_IDLE;  // [R7]
            end else begin
              state <= ST_DATA;  // [R3]
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Register space.
  logic [7:0] shd_a [PROG_COUNT];    // Channel A shadow copies.
  logic [7:0] shd_b [PROG_COUNT];    // Channel B shadow copies.
  logic [7:0] act_a [PROG_COUNT];    // Channel A active copies.
  logic [7:0] act_b [PROG_COUNT];    // Channel B active copies.
  logic       wr_en;                 // Data byte written this cycle.
  logic       wr_prog;               // Write lands in the program range.
  logic [4:0] wr_idx;                // Program index of the write.
  logic [4:0] rd_idx;                // Program index of the read.
  assign wr_en    = byte_done && !is_read;  // [R12]
  assign wr_prog  = addr >= ADDR_PROG_LO && addr <= ADDR_PROG_HI;  // [R21]
  assign wr_idx   = 5'(addr - ADDR_PROG_LO);
  assign soft_rst = wr_en && addr == ADDR_PORT_CFG && (wr_byte[CFG_RST_HI] | wr_byte[CFG_RST_LO]);
  assign xfer     = wr_en && addr == ADDR_TRANSFER && wr_byte[XFER_BIT];  // [R22]

  // Global configuration: bit order and channel index; soft reset restores both.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lsb_first_o   <= PORT_CFG_DEFAULT[CFG_LSB_HI];  // [R11] [R20]
      chan_select_o <= INDEX_DEFAULT;  // [R20]
    end else if (soft_rst) begin
      lsb_first_o   <= PORT_CFG_DEFAULT[CFG_LSB_HI];  // [R20] [R25]
      chan_select_o <= INDEX_DEFAULT;
    end else if (wr_en && addr == ADDR_PORT_CFG) begin
      lsb_first_o   <= wr_byte[CFG_LSB_HI] | wr_byte[CFG_LSB_LO];  // [R25]
    end else if (wr_en && addr == ADDR_INDEX) begin
      chan_select_o <= wr_byte[1:0];  // [R23]
    end
  end

  // Shadow and active program registers; a transfer copies all at once.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < PROG_COUNT; i++) begin
        shd_a[i] <= PROG_DEFAULT;  // [R20]
        shd_b[i] <= PROG_DEFAULT;
        act_a[i] <= PROG_DEFAULT;
        act_b[i] <= PROG_DEFAULT;
      end
    end else if (soft_rst) begin
      for (int i = 0; i < PROG_COUNT; i++) begin
        shd_a[i] <= PROG_DEFAULT;  // [R20]
        shd_b[i] <= PROG_DEFAULT;
        act_a[i] <= PROG_DEFAULT;
        act_b[i] <= PROG_DEFAULT;
      end
    end else begin
      if (wr_en && wr_prog && chan_select_o[0]) begin
        shd_a[wr_idx] <= wr_byte;  // [R22] [R23]
      end
      if (wr_en && wr_prog && chan_select_o[1]) begin
        shd_b[wr_idx] <= wr_byte;  // [R22] [R23]
      end
      if (xfer) begin
        for (int i = 0; i < PROG_COUNT; i++) begin
          act_a[i] <= shd_a[i];  // [R22]
          act_b[i] <= shd_b[i];
        end
      end
    end
  end

  // Transfer pulse; the transfer bit itself is never stored, so it reads zero.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      transfer_o <= 1'b0;
    end else begin
      transfer_o <= xfer;  // [R22]
    end
  end

  // Read value for the byte about to be shifted out.
  assign rd_addr = (state == ST_INSTR) ? instr[ADDR_BITS-1:0] : step_addr(addr, lsb_first_o);
  assign rd_idx  = 5'(rd_addr - ADDR_PROG_LO);
  always_comb begin
    rd_val = 8'h00;
    if (rd_addr == ADDR_PORT_CFG) begin
      rd_val = {1'b0, lsb_first_o, 1'b0, 2'b11, 1'b0, lsb_first_o, 1'b0};  // [R25]
    end else if (rd_addr == ADDR_CHIP_ID) begin
      rd_val = CHIP_ID;  // [R21] [R24]
    end else if (rd_addr == ADDR_GRADE) begin
      rd_val = GRADE_DEFAULT;  // [R21]
    end else if (rd_addr == ADDR_INDEX) begin
      rd_val = {6'h00, chan_select_o};  // [R21]
    end else if (rd_addr >= ADDR_PROG_LO && rd_addr <= ADDR_PROG_HI) begin
      // Channel A answers whenever its bit is set, including both set.
      rd_val = chan_select_o[0] ? shd_a[rd_idx] : shd_b[rd_idx];  // [R24]
    end else begin
      rd_val = 8'h00;  // Unpopulated locations read zero.
    end
  end

  // Readback shifter: loaded at each byte boundary, bits driven on falling edges.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_byte                 <= '0;
      data_or_powerdown_pin_o <= 1'b0;
      data_pin_oe_o           <= 1'b0;
    end else begin
      if (instr_done || byte_done) begin
        rd_byte <= rd_val;
      end
      if (fall && state == ST_DATA && is_read) begin
        data_or_powerdown_pin_o <= lsb_first_o ? rd_byte[bitcnt[2:0]]
                                               : rd_byte[3'(3'h7 - bitcnt[2:0])];  // [R27]
      end
      // Drive only in a read data phase with select low.
      data_pin_oe_o <= !cs_s && state == ST_DATA && is_read;  // [R5] [R10] [R12]
    end
  end

  // Strap logic: power-down level caught once after reset; OE strap followed live.
  logic [1:0] strap_cnt;             // Settling count for the synchroniser.
  logic       strap_pd;              // Captured power-down strap.
  logic       port_used;             // A frame has been seen since reset.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_cnt <= '0;
      strap_pd  <= 1'b1;
      port_used <= 1'b0;
    end else begin
      if (strap_cnt < STRAP_SETTLE) begin
        strap_cnt <= 2'(strap_cnt + 2'h1);
      end else if (strap_cnt == STRAP_SETTLE && !port_used && cs_s) begin
        strap_cnt <= 2'h3;
        strap_pd  <= sd_s;  // [R14] [R16]
      end
      if (rise) begin
        port_used <= 1'b1;
      end
    end
  end

  // Static control outputs.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      full_power_down_o <= 1'b1;
      outputs_hiz_o     <= 1'b0;
    end else begin
      full_power_down_o <= !port_used && strap_pd;  // [R14] [R16]
      outputs_hiz_o     <= oe_s;  // [R15]
    end
  end

  // Observation of the active program registers.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_data_a_o <= PROG_DEFAULT;
      cfg_data_b_o <= PROG_DEFAULT;
    end else if (cfg_index_i < 5'(PROG_COUNT)) begin
      cfg_data_a_o <= act_a[cfg_index_i];
      cfg_data_b_o <= act_b[cfg_index_i];
    end else begin
      cfg_data_a_o <= 8'h00;
      cfg_data_b_o <= 8'h00;
    end
  end

  // Checks.
  a_frame_start: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)  // [R1]
    (state == ST_IDLE && rise) |=> state == ST_INSTR)
    else $error("frame did not start on select low and clock rise");
  a_select_gates: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)  // [R2]
    cs_s |=> $stable(shreg))
    else $error("shifter moved while select high");
  a_hiz_when_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)  // [R5]
    data_pin_oe_o |-> $past(!cs_s))
    else $error("data pin driven while select high");
  a_instr_sixteen: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)  // [R6]
    (state == ST_INSTR && rise && bitcnt == 4'he) |=> state == ST_INSTR)
    else $error("instruction phase ended early");
  a_length_end: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)  // [R7]
    (byte_done && len_code == LEN_ONE) |=> state == ST_IDLE)
    else $error("single byte frame did not end");
  a_stream_stays: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)  // [R3]
    (byte_done && len_code == LEN_STREAM) |=> state == ST_DATA && bitcnt == 4'h0)
    else $error("streaming frame stopped");
  a_write_no_drive: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)  // [R12]
    (state == ST_DATA && !is_read) |=> !data_pin_oe_o)
    else $error("data pin driven in write phase");
  a_read_turnaround: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)  // [R10]
    (instr_done && instr[INSTR_RW_BIT]) ##1 !cs_s |=> data_pin_oe_o)
    else $error("readback did not turn pin around");
  a_transfer_copy: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)  // [R22]
    (xfer && !soft_rst) |=> act_a[0] == $past(shd_a[0]) && transfer_o)
    else $error("transfer did not copy shadow");
  a_soft_reset: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)  // [R20]
    soft_rst |=> !lsb_first_o && chan_select_o == INDEX_DEFAULT)
    else $error("soft reset left non-default values");

endmodule

/* File: spi_host_model.sv */
// Serial master that stands in for the host on the far side of the port.
module spi_host_model (
  input  wire logic clk_sys_i,  // System clock that paces the host.
  input  wire logic pin_i,      // Resolved level of the data pin.
  output logic      sclk_o,     // Serial clock, idles low.
  output logic      cs_n_o,     // Chip select, active low.
  output logic      sdo_o,      // Value the host drives on the data pin.
  output logic      sdo_oe_o    // High while the host drives the data pin.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lsb = 1'b0;             // Shift order assumed by the host, high for LSB first.

  // The port stays idle between frames: clock low, select high, pin released.
  initial begin
    sclk_o   = 1'b0;
    cs_n_o   = 1'b1;
    sdo_o    = 1'b0;
    sdo_oe_o = 1'b0;
  end

  // Waits a number of system clock edges.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // Drives one bit at the falling edge and samples the pin just after the rise.
  task automatic send(input logic v, output logic s);
    sclk_o <= 1'b0;
    sdo_o  <= v;
    tick(4);
    sclk_o <= 1'b1;
    tick(2);
    s = pin_i;
    tick(2);
  endtask

  // Runs one frame; the first byte sits highest in the nb low bytes of wd.
  task automatic frame(input logic rd, input logic [1:0] len, input logic [12:0] addr,
                       input int nb, input logic [31:0] wd, input bit stall,
                       input bit gate_off, output logic [31:0] rdv);
    logic [15:0] ins;
    logic [7:0]  b;
    logic [7:0]  got;
    logic        s;
    ins = {rd, len, addr};
    if (lsb) ins = {<<{ins}};
    rdv = 32'h0;
    @(posedge clk_sys_i);
    cs_n_o   <= gate_off;
    sdo_oe_o <= 1'b1;
    for (int i = 0; i < 16; i++) send(ins[15-i], s);
    if (rd) sdo_oe_o <= 1'b0;
    for (int k = 0; k < nb; k++) begin
      b = wd[8*(nb-1-k) +: 8];
      if (lsb) b = {<<{b}};
      for (int i = 0; i < 8; i++) begin
        send(b[7-i], s);
        got[7-i] = s;
      end
      if (lsb) got = {<<{got}};
      rdv[8*(nb-1-k) +: 8] = got;
      // A stall raises select between bytes and lowers it again.
      if (stall && k < nb - 1) begin
        sclk_o <= 1'b0;
        tick(4);
        cs_n_o <= 1'b1;
        tick(8);
        cs_n_o <= 1'b0;
        tick(4);
      end
    end
    sclk_o <= 1'b0;
    tick(4);
    cs_n_o   <= 1'b1;
    sdo_oe_o <= 1'b0;
    tick(8);
  endtask
endmodule

/* File: test_adc_serial_config_port.sv */
// Self-checking bench for the serial configuration port.
module test_adc_serial_config_port;
  timeunit 1ns;
  timeprecision 1ns;
  import adc_serial_config_port_pkg::*;

  logic       clk_sys_i = 1'b0;  // System clock.
  logic       rst_n_i   = 1'b0;  // Reset, active low.
  logic       oe_strap_n = 1'b0; // Output-enable strap level.
  logic [4:0] cfg_index = 5'h00; // Program register index under observation.
  logic       strap = 1'b1;      // Level the data pin is strapped to.
  logic       sclk, cs_n, h_d, h_oe, pin;
  logic       dut_d, dut_oe, lsb_first, pd, hiz, xfer;
  logic [1:0] chan;
  logic [7:0] data_a, data_b;
  logic       saw_oe = 1'b0;     // Set when the block drives the pin.
  int         xfers = 0;         // Transfer pulses seen.
  int         failures = 0;      // Mismatches counted.
  int         total_checks = 0;  // Comparisons made.

  // The pin shows the driver that is enabled, else the strap level.
  assign pin = dut_oe ? dut_d : (h_oe ? h_d : strap);

  adc_serial_config_port DUT (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .chip_select_low_n_i(cs_n),
    .data_or_powerdown_pin_i(pin), .output_enable_n_i(oe_strap_n), .cfg_index_i(cfg_index),
    .data_or_powerdown_pin_o(dut_d), .data_pin_oe_o(dut_oe), .lsb_first_o(lsb_first),
    .chan_select_o(chan), .full_power_down_o(pd), .outputs_hiz_o(hiz),
    .transfer_o(xfer), .cfg_data_a_o(data_a), .cfg_data_b_o(data_b));

  spi_host_model host (
    .clk_sys_i(clk_sys_i), .pin_i(pin), .sclk_o(sclk), .cs_n_o(cs_n),
    .sdo_o(h_d), .sdo_oe_o(h_oe));

  // Clock generator, 100 ns period.
  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // Watches pin ownership and counts transfer pulses.
  always @(posedge clk_sys_i) begin
    if (dut_oe === 1'b1) saw_oe = 1'b1;
    if (xfer === 1'b1) xfers++;
    if (dut_oe === 1'b1 && h_oe === 1'b1) begin
      failures++;
      $display("mismatch pin_contention expected 0 seen 1");
    end
  end

  // Compares one value of up to a byte.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds reset for six cycles with the pin strapped to s.
  task automatic do_reset(input logic s);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    strap   <= s;
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
  endtask

  // Single-byte write.
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [31:0] v;
    host.frame(1'b0, LEN_ONE, a, 1, {24'h0, d}, 1'b0, 1'b0, v);
  endtask

  // Single-byte read, checked, with the pin turned around.
  task automatic rd(input logic [12:0] a, input logic [7:0] exp);
    logic [31:0] v;
    saw_oe = 1'b0;
    host.frame(1'b1, LEN_ONE, a, 1, 32'h0, 1'b0, 1'b0, v);
    chk("read_data", exp, v[7:0]);
    chk("pin_turned", 8'h01, {7'h0, saw_oe});
  endtask

  // Observes one active program register on both channels.
  task automatic chk_prog(input logic [4:0] idx, input logic [7:0] ea, input logic [7:0] eb);
    cfg_index <= idx;
    repeat (3) @(posedge clk_sys_i);
    chk("prog_a", ea, data_a);
    chk("prog_b", eb, data_b);
  endtask

  // Reset values, power-down strap high, and the chip configuration area.
  task automatic t_defaults;
    do_reset(1'b1);
    chk("power_down", 8'h01, {7'h0, pd});
    chk("chan", 8'h03, {6'h0, chan});
    chk("lsb_first", 8'h00, {7'h0, lsb_first});
    chk("pin_oe", 8'h00, {7'h0, dut_oe});
    rd(ADDR_PORT_CFG, 8'h18);
    rd(ADDR_CHIP_ID, 8'h5c);
    rd(ADDR_GRADE, 8'h00);
    chk("power_down", 8'h00, {7'h0, pd});
  endtask

  // Output-enable strap in both levels.
  task automatic t_oe_strap;
    oe_strap_n <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    chk("hiz", 8'h01, {7'h0, hiz});
    oe_strap_n <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    chk("hiz", 8'h00, {7'h0, hiz});
  endtask

  // Clocking a write with select held high changes nothing.
  task automatic t_gated;
    logic [31:0] v;
    host.frame(1'b0, LEN_ONE, ADDR_INDEX, 1, 32'h0, 1'b0, 1'b1, v);
    chk("chan", 8'h03, {6'h0, chan});
  endtask

  // Channel selection, shadowing and the self-clearing transfer.
  task automatic t_shadow;
    int n;
    wr(ADDR_INDEX, 8'h01);
    chk("chan", 8'h01, {6'h0, chan});
    rd(ADDR_INDEX, 8'h01);
    wr(ADDR_PROG_LO + 13'h1, 8'h3c);
    wr(ADDR_INDEX, 8'h02);
    wr(ADDR_PROG_LO + 13'h1, 8'h77);
    chk_prog(5'd1, 8'h00, 8'h00);
    n = xfers;
    wr(ADDR_TRANSFER, 8'h01);
    chk("transfers", 8'h01, 8'(xfers - n));
    chk_prog(5'd1, 8'h3c, 8'h77);
    rd(ADDR_TRANSFER, 8'h00);
    wr(ADDR_INDEX, 8'h03);
    rd(ADDR_PROG_LO + 13'h1, 8'h3c);
  endtask

  // Two bytes with a stall, a streamed run and three bytes, addresses falling.
  task automatic t_lengths;
    logic [31:0] v;
    host.frame(1'b0, LEN_TWO, 13'h000b, 2, 32'h1122, 1'b1, 1'b0, v);
    host.frame(1'b0, LEN_STREAM, 13'h000e, 3, 32'h334455, 1'b0, 1'b0, v);
    host.frame(1'b0, LEN_THREE, 13'h0017, 3, 32'h667788, 1'b0, 1'b0, v);
    wr(ADDR_TRANSFER, 8'h01);
    chk_prog(5'd3, 8'h11, 8'h11);
    chk_prog(5'd2, 8'h22, 8'h22);
    chk_prog(5'd6, 8'h33, 8'h33);
    chk_prog(5'd4, 8'h55, 8'h55);
    chk_prog(5'd15, 8'h66, 8'h66);
    chk_prog(5'd13, 8'h88, 8'h88);
  endtask

  // LSB-first order, rising addresses, then soft reset back to defaults.
  task automatic t_lsb;
    logic [31:0] v;
    wr(ADDR_PORT_CFG, 8'h42);
    chk("lsb_first", 8'h01, {7'h0, lsb_first});
    host.lsb = 1'b1;
    rd(ADDR_INDEX, 8'h03);
    host.frame(1'b0, LEN_TWO, 13'h0018, 2, 32'h99aa, 1'b0, 1'b0, v);
    wr(ADDR_TRANSFER, 8'h01);
    chk_prog(5'd16, 8'h99, 8'h99);
    chk_prog(5'd17, 8'haa, 8'haa);
    wr(ADDR_PORT_CFG, 8'h24);
    host.lsb = 1'b0;
    chk("lsb_first", 8'h00, {7'h0, lsb_first});
    chk("chan", 8'h03, {6'h0, chan});
  endtask

  // Power-on with the pin strapped low selects normal operation.
  task automatic t_strap_low;
    do_reset(1'b0);
    chk("power_down", 8'h00, {7'h0, pd});
    // The strap level is latched once, so a later change must not show.
    strap <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    chk("power_down", 8'h00, {7'h0, pd});
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    failures++;
    $display("mismatch watchdog expected done seen hang");
    wrap_up();
  end

  // Main sequence.
  initial begin
    t_defaults();
    t_oe_strap();
    t_gated();
    t_shadow();
    t_lengths();
    t_lsb();
    t_strap_low();
    wrap_up();
  end
endmodule
